// File: src/psnv_pkg.sv
// Constants and types shared by the program-space and nonvolatile access block.
package psnv_pkg;

  // Register bus geometry.
  localparam int unsigned PSNV_AW = 3;
  localparam int unsigned PSNV_DW = 16;

  // Register word addresses.
  localparam logic [2:0] PSNV_CTRL_OFS = 3'h0;
  localparam logic [2:0] PSNV_TBLPG_OFS = 3'h1;
  localparam logic [2:0] PSNV_VISPG_OFS = 3'h2;
  localparam logic [2:0] PSNV_STAT_OFS = 3'h3;
  localparam logic [2:0] PSNV_MASK_OFS = 3'h4;

  // Fields of nv_operation_control.
  localparam int unsigned PSNV_START_BIT = 15;
  localparam int unsigned PSNV_PERMIT_BIT = 14;
  localparam int unsigned PSNV_ABORT_BIT = 13;
  localparam int unsigned PSNV_PGONLY_BIT = 12;
  localparam int unsigned PSNV_ERASE_BIT = 6;
  localparam int unsigned PSNV_OPC_MSB = 5;
  localparam logic [15:0] PSNV_CTRL_RST = 16'h0000;
  localparam logic [7:0] PSNV_PAGE_RST = 8'h00;

  // Operation codes for erase mode and the word counts they select.
  localparam logic [5:0] PSNV_OPC_ERASE8 = 6'h1A;
  localparam logic [5:0] PSNV_OPC_ERASE4 = 6'h19;
  localparam logic [5:0] PSNV_OPC_ERASE1 = 6'h18;
  localparam logic [3:0] PSNV_WORDS8 = 4'h8;
  localparam logic [3:0] PSNV_WORDS4 = 4'h4;
  localparam logic [3:0] PSNV_WORDS1 = 4'h1;
  localparam logic [3:0] PSNV_WORDS0 = 4'h0;

  // Address forming.
  localparam int unsigned PSNV_PAGE_MSB = 7;
  localparam int unsigned PSNV_EA_MSB = 15;

  // Interrupt status and mask layout.
  localparam int unsigned PSNV_IRQ_W = 2;
  localparam int unsigned PSNV_IRQ_DONE = 0;
  localparam int unsigned PSNV_IRQ_ABORT = 1;

  typedef enum logic [1:0] {
    PSNV_IDLE = 2'b01,
    PSNV_BUSY = 2'b10
  } psnv_state_e;

endpackage

// File: src/psnv_top.sv
// Program-space table and window access path with nonvolatile cycle control.
//
// How it works
// - Table address is page above effective address.
// - Page top bit selects configuration memory.
// - Window joins visibility page with fifteen bits.
// - Window is read-only, returns low word.
// - Table reads and writes reach every byte.
// - Start bit set-only; hardware clears at end.
// - Permit bit cleared when cycle completes.
// - Reset during cycle sets abort flag.
// - Program-only skips erase; other writes erase first.
// - Erase select picks erase or write.
// - Operation code sets erase size 8/4/1.
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none

module psnv_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [psnv_pkg::PSNV_AW-1:0] reg_addr,
  input wire logic [psnv_pkg::PSNV_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output var logic [psnv_pkg::PSNV_DW-1:0] reg_rdata,
  output var logic irq,
  input wire logic tbl_rd,
  input wire logic tbl_wr,
  input wire logic tbl_upper,
  input wire logic win_rd,
  input wire logic [15:0] effective_address,
  input wire logic [15:0] core_wdata,
  output var logic [15:0] core_rdata,
  output var logic core_rvalid,
  output var logic [23:0] prog_addr,
  output var logic prog_cfg_sel,
  output var logic prog_rd,
  output var logic prog_wr,
  output var logic prog_wr_upper,
  output var logic [15:0] prog_wdata,
  input wire logic [23:0] prog_rdata,
  output var logic nv_cycle_req,
  output var logic nv_erase,
  output var logic nv_pre_erase,
  output var logic [5:0] nv_operation_code,
  output var logic [3:0] nv_erase_words,
  input wire logic nv_cycle_done,
  input wire logic master_clear_reset_n,
  input wire logic watchdog_reset
);
  import psnv_pkg::*;
  // Master clear arrives from a pin and is synchronised first.
  logic master_clear_reset_meta_q, master_clear_reset_sync_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      master_clear_reset_meta_q <= 1'h1;
      master_clear_reset_sync_q <= 1'h1;
    end else begin
      master_clear_reset_meta_q <= master_clear_reset_n;
      master_clear_reset_sync_q <= master_clear_reset_meta_q;
    end
  end
  logic rst_evt;
  assign rst_evt = !master_clear_reset_sync_q || watchdog_reset;
  // Control and status state.
  psnv_state_e state_q, state_d;
  logic start_q, start_d, permit_q, permit_d, abort_q, abort_d;
  logic pgonly_q, pgonly_d, erase_q, erase_d;
  logic [5:0] opc_q, opc_d;
  logic [7:0] tblpg_q, tblpg_d, vispg_q, vispg_d;
  logic [PSNV_IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d, evt;
  logic [15:0] rdata_q, rdata_d;
  logic irq_q, irq_d, cyc_q, cyc_d, pre_q, pre_d;
  logic [3:0] words_q, words_d;
  logic [15:0] ctrl_view;
  logic wr_ctrl, launch, done_ok, aborted;
  assign ctrl_view = {start_q, permit_q, abort_q, pgonly_q, 5'h00, erase_q,
                      opc_q};
  assign wr_ctrl = reg_wr && (reg_addr == PSNV_CTRL_OFS);
  // A start request needs the permit already set.
  assign launch = (state_q == PSNV_IDLE) && wr_ctrl && permit_q &&
                  reg_wdata[PSNV_START_BIT];
  assign aborted = (state_q == PSNV_BUSY) && rst_evt;
  assign done_ok = (state_q == PSNV_BUSY) && nv_cycle_done && !rst_evt;
  always_comb begin
    state_d = state_q;
    start_d = start_q;
    permit_d = permit_q;
    abort_d = abort_q;
    pgonly_d = pgonly_q;
    erase_d = erase_q;
    opc_d = opc_q;
    tblpg_d = tblpg_q;
    vispg_d = vispg_q;
    mask_d = mask_q;
    cyc_d = cyc_q;
    pre_d = pre_q;
    words_d = words_q;
    evt = '0;
    // Mode fields are frozen while a cycle runs so the array sees one mode.
    if (wr_ctrl && state_q == PSNV_IDLE) begin
      permit_d = reg_wdata[PSNV_PERMIT_BIT];
      abort_d = reg_wdata[PSNV_ABORT_BIT];
      pgonly_d = reg_wdata[PSNV_PGONLY_BIT];
      erase_d = reg_wdata[PSNV_ERASE_BIT];
      opc_d = reg_wdata[PSNV_OPC_MSB:0];
    end
    if (reg_wr && reg_addr == PSNV_TBLPG_OFS) begin
      tblpg_d = reg_wdata[PSNV_PAGE_MSB:0];
    end
    if (reg_wr && reg_addr == PSNV_VISPG_OFS) begin
      vispg_d = reg_wdata[PSNV_PAGE_MSB:0];
    end
    if (reg_wr && reg_addr == PSNV_MASK_OFS) begin
      mask_d = reg_wdata[PSNV_IRQ_W-1:0];
    end
    unique case (state_q)
      PSNV_IDLE: begin
        if (launch) begin
          state_d = PSNV_BUSY;
          start_d = 1'h1;
          cyc_d = 1'h1;
          // Erase or write comes from the mode as it stands after this write.
          erase_d = reg_wdata[PSNV_ERASE_BIT];
          pre_d = !reg_wdata[PSNV_ERASE_BIT] &&
                  !reg_wdata[PSNV_PGONLY_BIT];
          unique case (reg_wdata[PSNV_OPC_MSB:0])
            PSNV_OPC_ERASE8: words_d = PSNV_WORDS8;
            PSNV_OPC_ERASE4: words_d = PSNV_WORDS4;
            PSNV_OPC_ERASE1: words_d = PSNV_WORDS1;
            default: words_d = PSNV_WORDS0;
          endcase
          if (!reg_wdata[PSNV_ERASE_BIT]) begin
            words_d = PSNV_WORDS0;
          end
        end
      end
      PSNV_BUSY: begin
        // Software writing zero to start has no effect here.
        if (aborted) begin
          state_d = PSNV_IDLE;
          start_d = 1'h0;
          permit_d = 1'h0;
          abort_d = 1'h1;
          cyc_d = 1'h0;
          evt[PSNV_IRQ_ABORT] = 1'h1;
        end else if (done_ok) begin
          state_d = PSNV_IDLE;
          start_d = 1'h0;
          permit_d = 1'h0;
          abort_d = 1'h0;
          cyc_d = 1'h0;
          evt[PSNV_IRQ_DONE] = 1'h1;
        end
      end
    endcase
    // A read clears status, but an event in the same cycle still lands.
    stat_d = ((reg_rd && reg_addr == PSNV_STAT_OFS) ? '0 : stat_q) | evt;
    irq_d = |(stat_d & mask_d);
    rdata_d = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        PSNV_CTRL_OFS: rdata_d = ctrl_view;
        PSNV_TBLPG_OFS: rdata_d = {8'h00, tblpg_q};
        PSNV_VISPG_OFS: rdata_d = {8'h00, vispg_q};
        PSNV_STAT_OFS: rdata_d = {14'h0000, stat_q};
        PSNV_MASK_OFS: rdata_d = {14'h0000, mask_q};
        default: rdata_d = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= PSNV_IDLE;
      {start_q, permit_q, abort_q, pgonly_q} <= PSNV_CTRL_RST[15:12];
      erase_q <= PSNV_CTRL_RST[PSNV_ERASE_BIT];
      opc_q <= PSNV_CTRL_RST[PSNV_OPC_MSB:0];
      tblpg_q <= PSNV_PAGE_RST;
      vispg_q <= PSNV_PAGE_RST;
      stat_q <= '0;
      mask_q <= '0;
      rdata_q <= 16'h0000;
      irq_q <= 1'h0;
      cyc_q <= 1'h0;
      pre_q <= 1'h0;
      words_q <= PSNV_WORDS0;
    end else begin
      state_q <= state_d;
      start_q <= start_d;
      permit_q <= permit_d;
      abort_q <= abort_d;
      pgonly_q <= pgonly_d;
      erase_q <= erase_d;
      opc_q <= opc_d;
      tblpg_q <= tblpg_d;
      vispg_q <= vispg_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      cyc_q <= cyc_d;
      pre_q <= pre_d;
      words_q <= words_d;
    end
  end
  // Access path: request, array strobe, array data, answer to the core.
  logic [23:0] pa_q, pa_d;
  logic pcfg_q, pcfg_d, prd_q, prd_d, pwr_q, pwr_d, pup_q, pup_d;
  logic [15:0] pwd_q, pwd_d, crd_q, crd_d;
  logic wsel_q, wsel_d, wait_q, wait_d, rv_q, rv_d, rsel_q;
  logic win_ok;
  // Window requests with the top address bit clear are ordinary data space.
  assign win_ok = win_rd && effective_address[PSNV_EA_MSB] && !tbl_rd &&
                  !tbl_wr;
  always_comb begin
    pa_d = pa_q;
    pcfg_d = pcfg_q;
    prd_d = 1'h0;
    pwr_d = 1'h0;
    pup_d = pup_q;
    pwd_d = pwd_q;
    wsel_d = 1'h0;
    if (tbl_rd || tbl_wr) begin
      pa_d = {tblpg_q, effective_address};
      pcfg_d = tblpg_q[PSNV_PAGE_MSB];
      prd_d = tbl_rd;
      pwr_d = tbl_wr && !tbl_rd;
      pup_d = tbl_upper;
      pwd_d = core_wdata;
      wsel_d = tbl_upper;
    end else if (win_ok) begin
      // The window never drives a write strobe into the array.
      pa_d = {1'h0, vispg_q, effective_address[PSNV_EA_MSB-1:0]};
      pcfg_d = 1'h0;
      prd_d = 1'h1;
      pup_d = 1'h0;
    end
    wait_d = prd_q;
    rv_d = wait_q;
    crd_d = crd_q;
    if (wait_q) begin
      crd_d = wsel_q ? {8'h00, prog_rdata[23:16]} :
              prog_rdata[15:0];
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pa_q <= 24'h000000;
      pcfg_q <= 1'h0;
      prd_q <= 1'h0;
      pwr_q <= 1'h0;
      pup_q <= 1'h0;
      pwd_q <= 16'h0000;
      rsel_q <= 1'h0;
      wsel_q <= 1'h0;
      wait_q <= 1'h0;
      rv_q <= 1'h0;
      crd_q <= 16'h0000;
    end else begin
      pa_q <= pa_d;
      pcfg_q <= pcfg_d;
      prd_q <= prd_d;
      pwr_q <= pwr_d;
      pup_q <= pup_d;
      pwd_q <= pwd_d;
      rsel_q <= wsel_d;
      wsel_q <= rsel_q;
      wait_q <= wait_d;
      rv_q <= rv_d;
      crd_q <= crd_d;
    end
  end
  assign reg_rdata = rdata_q;
  assign irq = irq_q;
  assign core_rdata = crd_q;
  assign core_rvalid = rv_q;
  assign prog_addr = pa_q;
  assign prog_cfg_sel = pcfg_q;
  assign prog_rd = prd_q;
  assign prog_wr = pwr_q;
  assign prog_wr_upper = pup_q;
  assign prog_wdata = pwd_q;
  assign nv_cycle_req = cyc_q;
  assign nv_erase = erase_q;
  assign nv_pre_erase = pre_q;
  assign nv_operation_code = opc_q;
  assign nv_erase_words = words_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence tbl_req_s;
    (tbl_rd || tbl_wr);
  endsequence
  sequence win_req_s;
    win_ok;
  endsequence
  start_needs_permit_a: assert property (
    (state_q == PSNV_IDLE && wr_ctrl && !permit_q) |=> !start_q && !cyc_q)
    else $error("Cycle began without write permit.");
  start_held_a: assert property (
    (start_q && !nv_cycle_done && !rst_evt) |=> start_q)
    else $error("Start bit dropped before the cycle ended.");
  done_clears_a: assert property (
    done_ok |=> !start_q && !permit_q && !abort_q && stat_q[PSNV_IRQ_DONE])
    else $error("Completion did not clear start and permit.");
  abort_flag_a: assert property (
    aborted |=> abort_q && !start_q && !nv_cycle_req)
    else $error("Interrupted cycle did not raise the abort flag.");
  table_addr_a: assert property (
    tbl_req_s |=> prog_addr == {$past(tblpg_q), $past(effective_address)}
      && prog_cfg_sel == $past(tblpg_q[PSNV_PAGE_MSB]))
    else $error("Table address formed wrongly.");
  window_addr_a: assert property (
    win_req_s |=> prog_addr[23] == 1'h0 && !prog_wr && prog_rd &&
      prog_addr[22:15] == $past(vispg_q) &&
      prog_addr[14:0] == $past(effective_address[14:0]))
    else $error("Window address formed wrongly.");
  window_low_word_a: assert property (
    win_req_s ##2 1'h1 |=> core_rvalid && core_rdata == $past(prog_rdata[15:0]))
    else $error("Window read did not return the low word.");
  upper_byte_a: assert property (
    (tbl_rd && tbl_upper) ##2 1'h1 |=>
      core_rvalid && core_rdata == {8'h00, $past(prog_rdata[23:16])})
    else $error("Upper byte read returned wrong data.");
  erase_mode_a: assert property (
    launch |=> nv_cycle_req && nv_erase == $past(reg_wdata[PSNV_ERASE_BIT]))
    else $error("Erase select not applied at launch.");
  pre_erase_a: assert property (
    launch |=> nv_pre_erase == (!$past(reg_wdata[PSNV_ERASE_BIT]) &&
      !$past(reg_wdata[PSNV_PGONLY_BIT])))
    else $error("Pre-erase choice wrong at launch.");
  erase_size_a: assert property (
    (launch && reg_wdata[PSNV_ERASE_BIT] &&
      reg_wdata[PSNV_OPC_MSB:0] == PSNV_OPC_ERASE8) |=>
      nv_erase_words == PSNV_WORDS8)
    else $error("Erase size for eight words wrong.");
endmodule

`default_nettype wire

// File: sim/psnv_array_model.sv
// Behavioural nonvolatile array facing the block's program-side port.
`timescale 1ns/100ps
`default_nettype none
module psnv_array_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic prog_rd,
  input wire logic [23:0] prog_addr,
  input wire logic nv_cycle_req,
  input wire logic [7:0] done_dly,
  output var logic [23:0] prog_rdata,
  output var logic nv_cycle_done
);
  int cnt;
  // Outside its one valid cycle the read bus inverts every clock.
  // A sample one cycle late then sees garbage, though two cycles late it matches again.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prog_rdata <= 24'h000000;
      nv_cycle_done <= 1'b0;
      cnt <= 0;
    end else begin
      if (prog_rd) begin
        prog_rdata <= prog_addr ^ 24'hA5C33C;
      end else begin
        prog_rdata <= ~prog_rdata;
      end
      nv_cycle_done <= nv_cycle_req && (cnt + 1 == done_dly);
      cnt <= nv_cycle_req ? cnt + 1 : 0;
    end
  end
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the program-space and nonvolatile control block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import psnv_pkg::*;
  logic clk = 1'b0;
  logic arst_n, reg_wr, reg_rd, irq, tbl_rd, tbl_wr, tbl_upper, win_rd;
  logic core_rvalid, prog_cfg_sel, prog_rd, prog_wr, prog_wr_upper;
  logic nv_cycle_req, nv_erase, nv_pre_erase, nv_cycle_done, up;
  logic master_clear_reset_n, watchdog_reset;
  logic [2:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, effective_address, core_wdata;
  logic [15:0] core_rdata, prog_wdata, ea, wd;
  logic [23:0] prog_addr, prog_rdata;
  logic [5:0] nv_operation_code;
  logic [3:0] nv_erase_words;
  logic [7:0] done_dly, tp, vp;
  int fails = 0, checked = 0, cyc = 0, n, k;
  int seed = 32'hDD12034C;
  logic [15:0] cfg [6] = '{16'h005A, 16'h0059, 16'h0058, 16'h0043,
    16'h0004, 16'h1004};
  logic [3:0] wexp [6] = '{4'h8, 4'h4, 4'h1, 4'h0, 4'h0, 4'h0};

  always #50 clk = ~clk;

  psnv_top dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .tbl_rd(tbl_rd), .tbl_wr(tbl_wr),
    .tbl_upper(tbl_upper), .win_rd(win_rd),
    .effective_address(effective_address), .core_wdata(core_wdata),
    .core_rdata(core_rdata), .core_rvalid(core_rvalid),
    .prog_addr(prog_addr), .prog_cfg_sel(prog_cfg_sel), .prog_rd(prog_rd),
    .prog_wr(prog_wr), .prog_wr_upper(prog_wr_upper),
    .prog_wdata(prog_wdata), .prog_rdata(prog_rdata),
    .nv_cycle_req(nv_cycle_req), .nv_erase(nv_erase),
    .nv_pre_erase(nv_pre_erase), .nv_operation_code(nv_operation_code),
    .nv_erase_words(nv_erase_words), .nv_cycle_done(nv_cycle_done),
    .master_clear_reset_n(master_clear_reset_n),
    .watchdog_reset(watchdog_reset));

  psnv_array_model array (.clk(clk), .arst_n(arst_n), .prog_rd(prog_rd),
    .prog_addr(prog_addr), .nv_cycle_req(nv_cycle_req),
    .done_dly(done_dly), .prog_rdata(prog_rdata),
    .nv_cycle_done(nv_cycle_done));

  task automatic report_and_stop;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_flag(input logic g, input logic e);
    chk({23'h000000, g}, {23'h000000, e});
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, e});
  endtask

  // One core request, checked at the array strobe and at the answer.
  task automatic acc(input int kd);
    logic [23:0] a;
    logic [23:0] m;
    a = (kd >= 2) ? {1'b0, vp, ea[14:0]} : {tp, ea};
    m = a ^ 24'hA5C33C;
    @(posedge clk);
    tbl_rd <= (kd == 0);
    tbl_wr <= (kd == 1);
    win_rd <= (kd >= 2);
    tbl_upper <= up;
    effective_address <= ea;
    core_wdata <= wd;
    @(posedge clk);
    tbl_rd <= 1'b0;
    tbl_wr <= 1'b0;
    win_rd <= 1'b0;
    #1;
    chk_flag(prog_rd, kd == 0 || kd == 2);
    chk_flag(prog_wr, kd == 1);
    if (kd < 3) begin
      chk(prog_addr, a);
      chk_flag(prog_cfg_sel, kd < 2 && tp[7]);
    end
    if (kd == 1) begin
      chk({8'h00, prog_wdata}, {8'h00, wd});
      chk_flag(prog_wr_upper, up);
    end
    repeat (2) @(posedge clk);
    #1;
    chk_flag(core_rvalid, kd == 0 || kd == 2);
    if (kd == 0 || kd == 2) begin
      chk({8'h00, core_rdata}, (kd == 0 && up) ? {16'h0000, m[23:16]} :
        {8'h00, m[15:0]});
    end
  endtask

  // Events 0 and 3 let the cycle finish, 3 with the abort flag set at
  // launch so that a clean finish must clear it; 1 and 2 cut it short.
  task automatic run_cycle(input int i, input logic [7:0] dl, input int ev);
    logic [15:0] f;
    logic [15:0] go;
    logic cut;
    f = cfg[i];
    go = (ev == 3) ? 16'hE000 : 16'hC000;
    cut = (ev == 1 || ev == 2);
    done_dly <= dl;
    wr(PSNV_MASK_OFS, (i == 2) ? 16'h0000 : 16'h0003);
    wr(PSNV_CTRL_OFS, 16'h4000 | f);
    wr(PSNV_CTRL_OFS, go | f);
    chk_flag(nv_cycle_req, 1'b1);
    chk_flag(nv_erase, f[6]);
    chk({18'h00000, nv_operation_code}, {18'h00000, f[5:0]});
    chk({20'h00000, nv_erase_words}, {20'h00000, wexp[i]});
    chk_flag(nv_pre_erase, !f[6] && !f[12]);
    if (ev == 1) begin
      @(posedge clk);
      watchdog_reset <= 1'b1;
      @(posedge clk);
      watchdog_reset <= 1'b0;
    end else if (ev == 2) begin
      @(posedge clk);
      master_clear_reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      master_clear_reset_n <= 1'b1;
    end else if (dl > 8'h08) begin
      wr(PSNV_CTRL_OFS, 16'h4000 | f);
      rd(PSNV_CTRL_OFS, go | f);
    end
    n = 0;
    while (nv_cycle_req === 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_flag(nv_cycle_req, 1'b0);
    @(posedge clk);
    #1;
    chk_flag(irq, i != 2);
    rd(PSNV_CTRL_OFS, cut ? (16'h2000 | f) : f);
    rd(PSNV_STAT_OFS, cut ? 16'h0002 : 16'h0001);
    @(posedge clk);
    #1;
    chk_flag(irq, 1'b0);
    $display("cycle run %0d event %0d done", i, ev);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      report_and_stop;
    end
  end

  initial begin
    {arst_n, reg_wr, reg_rd, tbl_rd, tbl_wr, tbl_upper, win_rd} = 7'h00;
    {watchdog_reset, reg_addr, reg_wdata} = 20'h00000;
    {effective_address, core_wdata} = 32'h00000000;
    master_clear_reset_n = 1'b1;
    done_dly = 8'h0C;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    for (n = 0; n < 5; n++) begin
      rd(n[2:0], 16'h0000);
    end
    wr(3'h5, 16'hFFFF);
    rd(3'h5, 16'h0000);
    wr(PSNV_CTRL_OFS, 16'h4FBF);
    rd(PSNV_CTRL_OFS, 16'h403F);
    wr(PSNV_CTRL_OFS, 16'h0000);
    wr(PSNV_CTRL_OFS, 16'h8000);
    chk_flag(nv_cycle_req, 1'b0);
    rd(PSNV_CTRL_OFS, 16'h0000);
    wr(PSNV_CTRL_OFS, 16'hC000);
    chk_flag(nv_cycle_req, 1'b0);
    rd(PSNV_CTRL_OFS, 16'h4000);
    $display("register test done");
    for (int i = 0; i < 6; i++) begin
      run_cycle(i, (i % 2 == 1) ? 8'h01 : 8'h0C, 0);
    end
    run_cycle(0, 8'h3C, 1);
    run_cycle(1, 8'h3C, 2);
    run_cycle(3, 8'h0C, 3);
    for (n = 0; n < 48; n++) begin
      if (n % 8 == 0) begin
        tp = $random(seed);
        vp = $random(seed);
        tp[7] = n[3];
        wr(PSNV_TBLPG_OFS, {8'h00, tp});
        wr(PSNV_VISPG_OFS, {8'h00, vp});
        rd(PSNV_TBLPG_OFS, {8'h00, tp});
      end
      k = $unsigned($random(seed)) % 4;
      ea = $random(seed);
      wd = $random(seed);
      up = ea[0] ^ wd[3];
      if (k >= 2) begin
        ea[15] = (k == 2);
      end
      acc(k);
    end
    $display("access test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
